// ### rtl/fmtc_defines.svh
/*
 * shared numeric constants of the tuner control block: widths, timing
 * figures and the cycle counts derived from them.
 * assumes a 50 MHz core clock and a 32.768 kHz reference on a pin.
 */
`ifndef FMTC_DEFINES_SVH
`define FMTC_DEFINES_SVH

`define FMTC_CLK_HZ 50000000
`define FMTC_WORD_W 14
`define FMTC_HIGH_W 6
`define FMTC_IFC_W 7
`define FMTC_LVL_W 4
// timing figures in their own units, reference ticks at 32.768 kHz
`define FMTC_REF_HZ_X1000 32768000
`define FMTC_SETTLE_MS 5
`define FMTC_LOCK_MIN_MS 2
`define FMTC_LOCK_MAX_MS 10
`define FMTC_SHORT_US 2000
`define FMTC_LONG_US 15600
// periods as reference ticks, lock minimum rounded up, the others rounded down
`define FMTC_SETTLE_TICKS ((`FMTC_SETTLE_MS * 32768) / 1000)
`define FMTC_LOCK_MIN_TICKS (((`FMTC_LOCK_MIN_MS * 32768) + 999) / 1000)
`define FMTC_LOCK_MAX_TICKS ((`FMTC_LOCK_MAX_MS * 32768) / 1000)
`define FMTC_SHORT_TICKS ((`FMTC_SHORT_US * 32768) / 1000000)
`define FMTC_LONG_TICKS ((`FMTC_LONG_US * 32768) / 1000000)
`define FMTC_TICK_W 10
// IF count valid window and level limits
`define FMTC_IF_LOW 7'h3E
`define FMTC_IF_HIGH 7'h42
`define FMTC_LVL_MIN 4'h3
`define FMTC_LVL_TUNED 4'h0
`define FMTC_HYST_SMALL 4'h1
`define FMTC_HYST_LARGE 4'h2
`define FMTC_PWR_OFF 2'h0
`define FMTC_PWR_FM_ONLY 2'h1

`endif

// ### rtl/fmtc_pkg.sv
/*
 * types of the tuner control block.
 * assumes fmtc_defines.svh is compiled first.
 */
package fmtc_pkg;

    typedef enum logic [2:0] {
        FMTC_IDLE,
        FMTC_SETTLE,
        FMTC_VALIDATE,
        FMTC_SEARCH,
        FMTC_TUNED
    } fmtc_state_e;

    // host-side byte write strobes
    typedef struct packed {
        logic freq_set_low_byte;
        logic freq_set_high_byte;
        logic tuner_control_one;
        logic tuner_control_two;
        logic test_bit_byte;
        logic test_select_byte;
    } fmtc_wr_s;

    // audio path controls
    typedef struct packed {
        logic left_oe_n;
        logic right_oe_n;
        logic silence;
        logic soft_mute_on;
        logic mono;
        logic switched_blend;
        logic noise_blend_on;
    } fmtc_audio_s;

endpackage

// ### rtl/fmtc_top.sv
/*
 * tuner control logic: tuning word load and trigger, settle and lock
 * timing, IF count and level flags, muting, blend, port pin, standby.
 * assumes the bus interface decodes byte writes into strobes with the
 * register bits held steady, and the reference arrives on an async pin.
 */
`timescale 1ns/1ps
`include "fmtc_defines.svh"

module fmtc_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // reference pin, 32.768 kHz
    input wire logic reference_input_pin,
    // register byte writes
    input wire fmtc_pkg::fmtc_wr_s wr,
    input wire logic [7:0] freq_set_low_byte,
    input wire logic [5:0] freq_set_high_byte,
    input wire logic search_select,
    input wire logic search_direction,
    input wire logic count_period_select,
    input wire logic hysteresis_step_select,
    input wire logic [`FMTC_LVL_W-1:0] level_threshold,
    // control bits
    input wire logic band_select,
    input wire logic wideband_agc_disable,
    input wire logic local_reception_select,
    input wire logic soft_mute_disable,
    input wire logic hard_mute_both,
    input wire logic left_channel_kill,
    input wire logic right_channel_kill,
    input wire logic audio_silence,
    input wire logic force_mono,
    input wire logic switched_blend,
    input wire logic noise_blend_disable,
    input wire logic port_source_select,
    input wire logic port_value_bit,
    input wire logic test_enable_bit,
    input wire logic test_port_value,
    input wire logic [1:0] power_state_bits,
    // analog front end observations
    input wire logic if_pulse,
    input wire logic [`FMTC_LVL_W-1:0] level_adc,
    // synthesizer and front end controls
    output logic [`FMTC_WORD_W-1:0] tuning_word,
    output logic synth_trigger,
    output logic search_active,
    output logic search_up,
    output logic band_low_range,
    output logic wideband_agc_on,
    output logic inband_agc_on,
    output logic lna_gain_reduced,
    output logic period_short,
    // status
    output logic pll_lock_flag,
    output logic tuning_done_flag,
    output logic [`FMTC_IFC_W-1:0] if_count,
    output logic if_flag,
    output logic [`FMTC_LVL_W-1:0] level_value,
    output logic low_level_flag,
    output logic rds_update,
    output logic rds_data_enable,
    // audio and power
    output fmtc_pkg::fmtc_audio_s audio,
    output logic general_output_pin,
    output logic fm_powered,
    output logic rds_powered
);

    // ==========================================================
    // reference synchroniser and edge tick
    logic ref_meta;
    logic ref_sync;
    logic ref_prev;
    logic ref_tick;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_meta <= 1'b0;
            ref_sync <= 1'b0;
            ref_prev <= 1'b0;
        end else begin
            ref_meta <= reference_input_pin;
            ref_sync <= ref_meta;
            ref_prev <= ref_sync;
        end
    end
    assign ref_tick = ref_sync & ~ref_prev;

    // ==========================================================
    // trigger and tuning word
    logic any_write;
    assign any_write = wr.freq_set_low_byte | wr.freq_set_high_byte | wr.tuner_control_one
        | wr.tuner_control_two | wr.test_bit_byte | wr.test_select_byte;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tuning_word <= '0;
            synth_trigger <= 1'b0;
        end else begin
            synth_trigger <= any_write;
            if (any_write) begin
                tuning_word <= {freq_set_high_byte, freq_set_low_byte};
            end
        end
    end

    // ==========================================================
    // tuning sequence
    fmtc_pkg::fmtc_state_e state;
    fmtc_pkg::fmtc_state_e next_state;
    logic [`FMTC_TICK_W-1:0] tick_cnt;
    logic period_sel_q;
    logic search_q;
    logic search_stop;
    // search stops only on a strong enough channel with a valid count
    assign search_stop = (level_adc >= `FMTC_LVL_MIN) && !if_flag;

    always_comb begin
        next_state = state;
        case (state)
            fmtc_pkg::FMTC_IDLE: begin
                if (synth_trigger) begin
                    next_state = fmtc_pkg::FMTC_SETTLE;
                end
            end
            fmtc_pkg::FMTC_SETTLE: begin
                if (ref_tick && tick_cnt >= `FMTC_TICK_W'(`FMTC_SETTLE_TICKS - 1)) begin
                    next_state = fmtc_pkg::FMTC_VALIDATE;
                end
            end
            fmtc_pkg::FMTC_VALIDATE: begin
                if (ref_tick && tick_cnt >= `FMTC_TICK_W'(`FMTC_LOCK_MIN_TICKS - 1)) begin
                    next_state = search_q ? fmtc_pkg::FMTC_SEARCH : fmtc_pkg::FMTC_TUNED;
                end
            end
            fmtc_pkg::FMTC_SEARCH: begin
                if (search_stop) begin
                    next_state = fmtc_pkg::FMTC_TUNED;
                end
            end
            fmtc_pkg::FMTC_TUNED: begin
                next_state = fmtc_pkg::FMTC_TUNED;
            end
            default: begin
                next_state = fmtc_pkg::FMTC_IDLE;
            end
        endcase
        if (synth_trigger) begin
            next_state = fmtc_pkg::FMTC_SETTLE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= fmtc_pkg::FMTC_IDLE;
            tick_cnt <= '0;
            search_q <= 1'b0;
            period_sel_q <= 1'b0;
            search_active <= 1'b0;
            search_up <= 1'b0;
        end else begin
            state <= next_state;
            search_active <= (next_state == fmtc_pkg::FMTC_SEARCH);
            search_up <= search_direction;
            if (synth_trigger) begin
                // period and mode latched at the start of the tuning cycle
                search_q <= search_select;
                period_sel_q <= count_period_select;
            end
            if (next_state != state) begin
                tick_cnt <= '0;
            end else if (ref_tick) begin
                tick_cnt <= tick_cnt + `FMTC_TICK_W'(1);
            end
        end
    end

    // lock flag and done flag, cleared by every retrigger
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_lock_flag <= 1'b0;
            tuning_done_flag <= 1'b0;
        end else if (synth_trigger) begin
            pll_lock_flag <= 1'b0;
            tuning_done_flag <= 1'b0;
        end else begin
            if (state == fmtc_pkg::FMTC_VALIDATE && next_state != state) begin
                pll_lock_flag <= 1'b1;
            end
            if (state != fmtc_pkg::FMTC_TUNED && next_state == fmtc_pkg::FMTC_TUNED) begin
                tuning_done_flag <= 1'b1;
            end
        end
    end

    // ==========================================================
    // IF counter, runs continuously over the chosen gate period
    logic tuned;
    logic [`FMTC_TICK_W-1:0] gate_cnt;
    logic [`FMTC_IFC_W-1:0] pulse_cnt;
    logic gate_end;
    logic use_short;

    assign tuned = (state == fmtc_pkg::FMTC_TUNED);
    assign use_short = period_sel_q && !tuned;
    assign gate_end = ref_tick && (gate_cnt >= (use_short ?
        `FMTC_TICK_W'(`FMTC_SHORT_TICKS - 1) : `FMTC_TICK_W'(`FMTC_LONG_TICKS - 1)));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_cnt <= '0;
            pulse_cnt <= '0;
            if_count <= '0;
            if_flag <= 1'b0;
        end else begin
            if (gate_end) begin
                gate_cnt <= '0;
                pulse_cnt <= '0;
                if_count <= pulse_cnt;
                if_flag <= (pulse_cnt < `FMTC_IF_LOW) || (pulse_cnt > `FMTC_IF_HIGH);
            end else begin
                if (ref_tick) begin
                    gate_cnt <= gate_cnt + `FMTC_TICK_W'(1);
                end
                if (if_pulse && pulse_cnt != '1) begin
                    pulse_cnt <= pulse_cnt + `FMTC_IFC_W'(1);
                end
            end
        end
    end

    // ==========================================================
    // level converter and low level flag with hysteresis
    logic [`FMTC_LVL_W-1:0] eff_limit;
    logic [`FMTC_LVL_W-1:0] hyst;

    // the tuned limit falls to zero, so the flag can no longer set
    assign eff_limit = tuned ? `FMTC_LVL_TUNED : level_threshold;
    assign hyst = hysteresis_step_select ? `FMTC_HYST_LARGE : `FMTC_HYST_SMALL;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_value <= '0;
            low_level_flag <= 1'b0;
        end else begin
            level_value <= level_adc;
            if (level_adc < eff_limit) begin
                low_level_flag <= 1'b1;
            end else if ({1'b0, level_adc} >= {1'b0, eff_limit} + {1'b0, hyst}) begin
                low_level_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // rds update and audio path
    logic standby;
    assign standby = (power_state_bits == `FMTC_PWR_OFF);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rds_update <= 1'b0;
            rds_data_enable <= 1'b0;
        end else begin
            // short period preset: update runs while the word settles and validates
            rds_update <= period_sel_q && !search_q && !tuned
                && state != fmtc_pkg::FMTC_IDLE;
            rds_data_enable <= audio_silence && !standby
                && power_state_bits != `FMTC_PWR_FM_ONLY;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            audio <= '{left_oe_n: 1'b1, right_oe_n: 1'b1, silence: 1'b1, soft_mute_on: 1'b1,
                mono: 1'b0, switched_blend: 1'b0, noise_blend_on: 1'b1};
        end else begin
            audio.left_oe_n <= hard_mute_both | left_channel_kill | standby;
            audio.right_oe_n <= hard_mute_both | right_channel_kill | standby;
            audio.silence <= audio_silence | rds_update;
            audio.soft_mute_on <= !soft_mute_disable;
            audio.mono <= force_mono | left_channel_kill | right_channel_kill;
            audio.switched_blend <= switched_blend;
            audio.noise_blend_on <= !noise_blend_disable;
        end
    end

    // ==========================================================
    // front end controls, port pin and power
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            band_low_range <= 1'b0;
            wideband_agc_on <= 1'b1;
            inband_agc_on <= 1'b1;
            lna_gain_reduced <= 1'b0;
            period_short <= 1'b0;
            general_output_pin <= 1'b0;
            fm_powered <= 1'b0;
            rds_powered <= 1'b0;
        end else begin
            band_low_range <= band_select;
            wideband_agc_on <= !wideband_agc_disable;
            inband_agc_on <= 1'b1;
            lna_gain_reduced <= local_reception_select;
            period_short <= use_short;
            // power bits play no part here
            general_output_pin <= test_enable_bit ? test_port_value
                : (port_source_select ? tuning_done_flag : port_value_bit);
            fm_powered <= !standby;
            rds_powered <= !standby && power_state_bits != `FMTC_PWR_FM_ONLY;
        end
    end

    // ==========================================================
    // checks
    trigger_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        any_write |=> synth_trigger) else $error("write did not retrigger");
    word_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        any_write |=> tuning_word == $past({freq_set_high_byte, freq_set_low_byte}))
        else $error("tuning word not loaded");
    lock_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        synth_trigger |=> !pll_lock_flag) else $error("lock flag survived retrigger");
    lock_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(pll_lock_flag) |-> $past(state) == fmtc_pkg::FMTC_VALIDATE)
        else $error("lock set outside validation");
    hard_mute_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (hard_mute_both || standby) |=> audio.left_oe_n && audio.right_oe_n)
        else $error("audio not tri-stated");
    kill_mono_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        left_channel_kill |=> audio.mono && audio.left_oe_n) else $error("left kill not applied");
    rds_silence_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rds_update |=> audio.silence) else $error("audio live during update");
    port_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!test_enable_bit && !port_source_select) |=> general_output_pin == $past(port_value_bit))
        else $error("port pin wrong");
    tuned_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (tuned && $past(tuned)) |=> !low_level_flag || $past(low_level_flag))
        else $error("low level set while tuned");
    rds_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !audio_silence |=> !rds_data_enable) else $error("rds data not halted");

endmodule

// ### dv/fmtc_host_model.sv
/*
 * host side model: free running reference oscillator and byte writer.
 * assumes the bench calls its tasks from a single process.
 */
`timescale 1ns/1ps
module fmtc_host_model (
    // clock
    input wire logic core_clk,
    // reference and byte writes
    output logic reference_input_pin,
    output fmtc_pkg::fmtc_wr_s wr,
    output logic [7:0] freq_set_low_byte,
    output logic [5:0] freq_set_high_byte
);
    // ========================================
    // reference
    // a crystal reference never stops; the odd offset keeps its edges off the core_clk edges
    initial begin
        reference_input_pin = 1'b0;
        wr = '0;
        freq_set_low_byte = 8'h00;
        freq_set_high_byte = 6'h00;
        #37;
        forever #80 reference_input_pin = ~reference_input_pin;
    end

    // ========================================
    // writes
    // one strobe cycle per write, bytes held afterwards like real registers
    task automatic send(input logic [5:0] strobes);
        @(negedge core_clk);
        wr = fmtc_pkg::fmtc_wr_s'(strobes);
        @(negedge core_clk);
        wr = '0;
    endtask

    task automatic tune(input int f_khz, input logic high_side);
        int word;
        word = (4 * (high_side ? f_khz + 225 : f_khz - 225) * 1000) / 32768;
        @(negedge core_clk);
        freq_set_high_byte = 6'(word >> 8);
        freq_set_low_byte = 8'(word);
        send(6'h10);
    endtask
endmodule

// ### dv/test_fmtc_top.sv
/*
 * self-checking bench of the tuner control block.
 * assumes the host model owns the reference pin and the byte writes.
 */
`timescale 1ns/1ps
`include "fmtc_defines.svh"
module test_fmtc_top;
    // ========================================
    // signals
    localparam int TICK_CYC = 8;
    localparam int LOCK_MIN = `FMTC_LOCK_MIN_TICKS * TICK_CYC;
    localparam int LOCK_MAX = (`FMTC_SETTLE_TICKS + `FMTC_LOCK_MAX_TICKS + 4) * TICK_CYC;
    localparam int LIMIT = 40000;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reference_input_pin;
    fmtc_pkg::fmtc_wr_s wr;
    logic [7:0] freq_set_low_byte;
    logic [5:0] freq_set_high_byte;
    logic search_select = 1'b0, search_direction = 1'b0, count_period_select = 1'b0;
    logic hysteresis_step_select = 1'b0, band_select = 1'b0, wideband_agc_disable = 1'b0;
    logic local_reception_select = 1'b0, soft_mute_disable = 1'b0, hard_mute_both = 1'b0;
    logic left_channel_kill = 1'b0, right_channel_kill = 1'b0, audio_silence = 1'b0;
    logic force_mono = 1'b0, switched_blend = 1'b0, noise_blend_disable = 1'b0;
    logic port_source_select = 1'b0, port_value_bit = 1'b0, test_enable_bit = 1'b0;
    logic test_port_value = 1'b0, if_pulse = 1'b0;
    logic [3:0] level_threshold = 4'h3, level_adc = 4'h0, level_value;
    logic [1:0] power_state_bits = 2'h0;
    logic [13:0] tuning_word;
    logic synth_trigger, search_active, search_up, band_low_range, wideband_agc_on;
    logic inband_agc_on, lna_gain_reduced, period_short, pll_lock_flag, tuning_done_flag;
    logic [6:0] if_count;
    logic if_flag, low_level_flag, rds_update, rds_data_enable, general_output_pin;
    logic fm_powered, rds_powered;
    fmtc_pkg::fmtc_audio_s audio;

    fmtc_host_model host (.*);
    fmtc_top DUT (.*);

    // ========================================
    // clock and timeout
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            results();
        end
    end

    // ========================================
    // helpers
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_vec(input string what, input logic [13:0] exp, input logic [13:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ========================================
    // scenarios
    task automatic test_controls(input logic v);
        @(negedge core_clk);
        band_select = v;
        wideband_agc_disable = v;
        local_reception_select = v;
        soft_mute_disable = v;
        force_mono = v;
        switched_blend = v;
        noise_blend_disable = v;
        cycles(2);
        check_bit("band_low_range", v, band_low_range);
        check_bit("wideband_agc_on", ~v, wideband_agc_on);
        check_bit("inband_agc_on", 1'b1, inband_agc_on);
        check_bit("lna_gain_reduced", v, lna_gain_reduced);
        check_bit("soft_mute_on", ~v, audio.soft_mute_on);
        check_bit("mono", v, audio.mono);
        check_bit("switched_blend", v, audio.switched_blend);
        check_bit("noise_blend_on", ~v, audio.noise_blend_on);
        $display("test controls finished");
    endtask
    // v holds hard mute, left kill, right kill, expected left_oe_n and right_oe_n
    task automatic mute_case(input logic [1:0] pw, input logic [4:0] v);
        @(negedge core_clk);
        power_state_bits = pw;
        {hard_mute_both, left_channel_kill, right_channel_kill} = v[4:2];
        cycles(2);
        check_bit("left_oe_n", v[1], audio.left_oe_n);
        check_bit("right_oe_n", v[0], audio.right_oe_n);
        check_bit("kill mono", v[3] | v[2], audio.mono);
        check_bit("fm_powered", pw != 2'h0, fm_powered);
        check_bit("rds_powered", pw[1], rds_powered);
        $display("test mute finished");
    endtask
    task automatic test_tune();
        int n;
        n = 0;
        @(negedge core_clk);
        count_period_select = 1'b1;
        search_select = 1'b0;
        host.tune(100100, 1'b1);
        check_bit("synth_trigger", 1'b1, synth_trigger);
        check_vec("tuning_word", 14'h2FD6, tuning_word);
        cycles(3);
        check_bit("period_short", 1'b1, period_short);
        check_bit("rds_update", 1'b1, rds_update);
        check_bit("auto silence", 1'b1, audio.silence);
        while (pll_lock_flag !== 1'b1 && n < LOCK_MAX) begin
            cycles(1);
            n++;
        end
        check_bit("lock time", 1'b1, n + 3 >= LOCK_MIN && n < LOCK_MAX);
        check_bit("tuning_done_flag", 1'b1, tuning_done_flag);
        cycles(2);
        check_bit("tuned period", 1'b0, period_short);
        $display("test tune finished");
    endtask
    task automatic test_tuned();
        @(negedge core_clk);
        level_adc = 4'h9;
        cycles(2);
        check_vec("level_value", 14'h0009, 14'(level_value));
        // below the host threshold: only the tuned limit keeps the flag low
        @(negedge core_clk);
        level_adc = 4'h2;
        cycles(8400);
        check_bit("low_level_flag", 1'b0, low_level_flag);
        check_vec("if_count idle", 14'h0000, 14'(if_count));
        check_bit("if_flag idle", 1'b1, if_flag);
        // one pulse every 64 cycles gives 63 or 64 counts per long gate
        repeat (200) begin
            @(negedge core_clk);
            if_pulse = 1'b1;
            @(negedge core_clk);
            if_pulse = 1'b0;
            repeat (62) @(negedge core_clk);
        end
        check_bit("if window", 1'b1, if_count >= `FMTC_IF_LOW && if_count <= `FMTC_IF_HIGH);
        check_bit("if_flag valid", 1'b0, if_flag);
        $display("test tuned finished");
    endtask
    // v holds silence bit, expected silence, expected data enable
    task automatic silence_case(input logic [1:0] pw, input logic [2:0] v);
        @(negedge core_clk);
        power_state_bits = pw;
        audio_silence = v[2];
        cycles(2);
        check_bit("silence", v[1], audio.silence);
        check_bit("rds_data_enable", v[0], rds_data_enable);
        $display("test silence finished");
    endtask
    // v holds source, value, test enable, test value, expected pin
    task automatic port_case(input logic [1:0] pw, input logic [4:0] v);
        @(negedge core_clk);
        power_state_bits = pw;
        {port_source_select, port_value_bit, test_enable_bit, test_port_value} = v[4:1];
        cycles(2);
        check_bit("general_output_pin", v[0], general_output_pin);
        $display("test port finished");
    endtask
    task automatic test_retrigger();
        for (int i = 0; i < 6; i++) begin
            host.send(6'(1 << i));
            check_bit("retrigger", 1'b1, synth_trigger);
            cycles(1);
            check_bit("done cleared", 1'b0, tuning_done_flag);
        end
        $display("test retrigger finished");
    endtask
    task automatic test_search(input logic dir);
        int n;
        n = 0;
        @(negedge core_clk);
        search_select = 1'b1;
        search_direction = dir;
        host.send(6'h10);
        cycles(2);
        check_bit("search restart", 1'b0, search_active);
        // the search only begins once settle and validation are over
        while (search_active !== 1'b1 && n < LOCK_MAX) begin
            cycles(1);
            n++;
        end
        check_bit("search_active", 1'b1, search_active);
        check_bit("search_up", dir, search_up);
        check_bit("search not done", 1'b0, tuning_done_flag);
        $display("test search finished");
    endtask
    // runs while searching, so the host threshold is the limit
    task automatic test_hyst();
        @(negedge core_clk);
        hysteresis_step_select = 1'b1;
        level_adc = 4'h2;
        cycles(2);
        check_bit("low flag set", 1'b1, low_level_flag);
        @(negedge core_clk);
        level_adc = 4'h4;
        cycles(2);
        check_bit("large step hold", 1'b1, low_level_flag);
        @(negedge core_clk);
        hysteresis_step_select = 1'b0;
        cycles(2);
        check_bit("small step clear", 1'b0, low_level_flag);
        @(negedge core_clk);
        level_threshold = 4'h5;
        cycles(2);
        check_bit("threshold raised", 1'b1, low_level_flag);
        $display("test hysteresis finished");
    endtask

    // ========================================
    // main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        cycles(2);
        check_bit("fm_powered", 1'b0, fm_powered);
        check_bit("rds_powered", 1'b0, rds_powered);
        check_bit("reset agc", 1'b1, wideband_agc_on);
        check_bit("reset left_oe_n", 1'b1, audio.left_oe_n);
        $display("test reset finished");
        test_controls(1'b1);
        test_controls(1'b0);
        mute_case(2'h2, 5'b10011);
        mute_case(2'h2, 5'b01010);
        mute_case(2'h2, 5'b00101);
        mute_case(2'h0, 5'b00011);
        mute_case(2'h1, 5'b00000);
        mute_case(2'h2, 5'b00000);
        test_tune();
        test_tuned();
        silence_case(2'h2, 3'b111);
        silence_case(2'h2, 3'b000);
        silence_case(2'h1, 3'b110);
        port_case(2'h2, 5'b10001);
        port_case(2'h0, 5'b01001);
        port_case(2'h2, 5'b00000);
        port_case(2'h2, 5'b01100);
        port_case(2'h2, 5'b00111);
        test_retrigger();
        test_search(1'b1);
        test_search(1'b0);
        test_hyst();
        results();
    end
endmodule
